// *** pkg/txobs_addr_pkg.sv ***
// Constants for the transmit observation and receive address registers.
// Assumes byte-wide register access from a host serial front end.
package txobs_addr_pkg;
    // Register indexes
    localparam logic [4:0] IDX_OBSERVE = 5'h08;
    localparam logic [4:0] IDX_CARRIER = 5'h09;
    localparam logic [4:0] IDX_PIPE0 = 5'h0a;
    localparam logic [4:0] IDX_PIPE1 = 5'h0b;
    localparam logic [4:0] IDX_PIPE2 = 5'h0c;
    localparam logic [4:0] IDX_PIPE3 = 5'h0d;
    localparam logic [4:0] IDX_PIPE4 = 5'h0e;
    localparam logic [4:0] IDX_PIPE5 = 5'h0f;
    // Field layout of the observation and carrier registers
    localparam int LOST_MSB = 7;
    localparam int LOST_LSB = 4;
    localparam int RETR_MSB = 3;
    localparam int RETR_LSB = 0;
    localparam logic [3:0] CNT_MAX = 4'hf;
    localparam logic [3:0] CNT_RESET = 4'h0;
    localparam int CARRIER_BIT = 0;
    // Reset values
    localparam logic [39:0] PIPE0_RESET = 40'he7_e7e7_e7e7;
    localparam logic [39:0] PIPE1_RESET = 40'hc2_c2c2_c2c2;
    localparam logic [7:0] PIPE2_RESET = 8'hc3;
    localparam logic [7:0] PIPE3_RESET = 8'hc4;
    localparam logic [7:0] PIPE4_RESET = 8'hc5;
    localparam logic [7:0] PIPE5_RESET = 8'hc6;
    // Address width codes and byte counts
    localparam logic [1:0] AW_ILLEGAL = 2'h0;
    localparam logic [1:0] AW_3 = 2'h1;
    localparam logic [1:0] AW_4 = 2'h2;
    localparam logic [1:0] AW_5 = 2'h3;
    localparam logic [2:0] BYTES_0 = 3'h0;
    localparam logic [2:0] BYTES_3 = 3'h3;
    localparam logic [2:0] BYTES_4 = 3'h4;
    localparam logic [2:0] BYTES_5 = 3'h5;
    localparam logic [2:0] BYTE_IDX_MAX = 3'h5;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// *** hw/tx_observe_counters.sv ***
// Lost-packet and retransmission counters of the observation register.
// Assumes one-cycle event pulses from logic on clk_sys.
`timescale 1ns/100ps
module tx_observe_counters
    import txobs_addr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Events
    input wire logic chan_write,
    input wire logic tx_new_packet,
    input wire logic tx_retransmit,
    input wire logic tx_lost,
    // Counters
    output logic [3:0] lost_cnt_r,
    output logic [3:0] retr_cnt_r
);
    logic [3:0] lost_cnt_nxt;
    logic [3:0] retr_cnt_nxt;

    always_comb
    begin
        lost_cnt_nxt = lost_cnt_r;
        // Loss in the clearing cycle still counts
        if (chan_write)
        begin
            lost_cnt_nxt = CNT_RESET;
        end
        if (tx_lost && lost_cnt_nxt != CNT_MAX)
        begin
            lost_cnt_nxt = lost_cnt_nxt + 4'h1;
        end
        retr_cnt_nxt = retr_cnt_r;
        if (tx_new_packet)
        begin
            retr_cnt_nxt = CNT_RESET;
        end
        else if (tx_retransmit && retr_cnt_r != CNT_MAX)
        begin
            retr_cnt_nxt = retr_cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            lost_cnt_r <= CNT_RESET;
            retr_cnt_r <= CNT_RESET;
        end
        else
        begin
            lost_cnt_r <= lost_cnt_nxt;
            retr_cnt_r <= retr_cnt_nxt;
        end
    end
endmodule

// *** hw/tx_observe_rx_address_regs.sv ***
// Observation counters, carrier flag and receive pipe address registers.
// Assumes a host front end on clk_sys that opens a register access with
// acc_start and then moves one byte per byte_valid pulse.
`timescale 1ns/100ps
// Function
// - Lost-packet count saturates at fifteen
// - Channel register write clears lost count
// - Retransmit count clears on new packet
// - Carrier flag bit zero, upper bits zero
// - Pipe 0 and 1 hold 40 bits
// - Address bytes low first, width-limited
// - Pipes 2-5 own low byte only
// - Pipe 0 resets to E7 bytes
// - Pipe 1 resets to C2 bytes
// - Pipes 2-5 reset C3 to C6
// - Width code picks 3,4,5 bytes
module tx_observe_rx_address_regs
    import txobs_addr_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Register access
    input wire logic acc_start,
    input wire logic [4:0] acc_index,
    input wire logic acc_write,
    input wire logic byte_valid,
    input wire logic [7:0] byte_wdata,
    output logic [7:0] rd_data_r,
    // Configuration, packet engine and carrier input
    input wire logic chan_write,
    input wire logic [1:0] address_width_setting,
    input wire logic tx_new_packet,
    input wire logic tx_retransmit,
    input wire logic tx_lost,
    input wire logic carrier_in,
    // Addresses, counters and carrier flag
    output logic [39:0] rx_pipe0_address,
    output logic [39:0] rx_pipe1_address,
    output logic [39:0] pipe2_full_r,
    output logic [39:0] pipe3_full_r,
    output logic [39:0] pipe4_full_r,
    output logic [39:0] pipe5_full_r,
    output logic [3:0] lost_packet_count,
    output logic [3:0] retransmit_count,
    output logic carrier_detect_flag
);
    logic [4:0] sel_r;
    logic [4:0] sel_nxt;
    logic wr_r;
    logic wr_nxt;
    logic [2:0] bidx_r;
    logic [2:0] bidx_nxt;
    logic [39:0] p0_nxt;
    logic [39:0] p1_nxt;
    logic [7:0] p2_r;
    logic [7:0] p3_r;
    logic [7:0] p4_r;
    logic [7:0] p5_r;
    logic [7:0] p2_nxt;
    logic [7:0] p3_nxt;
    logic [7:0] p4_nxt;
    logic [7:0] p5_nxt;
    logic [7:0] rd_nxt;
    logic [39:0] f2_nxt;
    logic [39:0] f3_nxt;
    logic [39:0] f4_nxt;
    logic [39:0] f5_nxt;
    logic cd_meta_r;
    logic cd_sync_r;
    logic wr_byte;

    // Address bytes accepted for the width code
    function automatic logic [2:0] width_bytes(input logic [1:0] aw);
        if (aw == AW_3)
            return BYTES_3;
        else if (aw == AW_4)
            return BYTES_4;
        else if (aw == AW_5)
            return BYTES_5;
        else
            return BYTES_0;
    endfunction

    // Byte n of a 40-bit value, zero past the end
    function automatic logic [7:0] byte_of(input logic [39:0] v,
                                           input logic [2:0] n);
        if (n < BYTE_IDX_MAX)
            return v[8*n +: 8];
        else
            return BYTE_ZERO;
    endfunction

    // Replace byte n of a 40-bit value
    function automatic logic [39:0] put_byte(input logic [39:0] v,
                                             input logic [2:0] n,
                                             input logic [7:0] b);
        logic [39:0] r;
        r = v;
        r[8*n +: 8] = b;
        return r;
    endfunction

    tx_observe_counters counters
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .chan_write(chan_write),
        .tx_new_packet(tx_new_packet),
        .tx_retransmit(tx_retransmit),
        .tx_lost(tx_lost),
        .lost_cnt_r(lost_packet_count),
        .retr_cnt_r(retransmit_count)
    );

    // Access tracking
    always_comb
    begin
        sel_nxt = sel_r;
        wr_nxt = wr_r;
        bidx_nxt = bidx_r;
        if (acc_start)
        begin
            sel_nxt = acc_index;
            wr_nxt = acc_write;
            bidx_nxt = 3'h0;
        end
        else if (byte_valid && bidx_r != BYTE_IDX_MAX)
        begin
            bidx_nxt = bidx_r + 3'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            sel_r <= 5'h00;
            wr_r <= 1'b0;
            bidx_r <= 3'h0;
        end
        else
        begin
            sel_r <= sel_nxt;
            wr_r <= wr_nxt;
            bidx_r <= bidx_nxt;
        end
    end

    assign wr_byte = byte_valid && wr_r && !acc_start;

    // Address storage
    always_comb
    begin
        p0_nxt = rx_pipe0_address;
        p1_nxt = rx_pipe1_address;
        p2_nxt = p2_r;
        p3_nxt = p3_r;
        p4_nxt = p4_r;
        p5_nxt = p5_r;
        if (wr_byte)
        begin
            if (sel_r == IDX_PIPE0)
            begin
                if (bidx_r < width_bytes(address_width_setting))
                    p0_nxt = put_byte(rx_pipe0_address, bidx_r,
                                      byte_wdata);
            end
            else if (sel_r == IDX_PIPE1)
            begin
                if (bidx_r < width_bytes(address_width_setting))
                    p1_nxt = put_byte(rx_pipe1_address, bidx_r,
                                      byte_wdata);
            end
            else if (bidx_r == 3'h0)
            begin
                if (sel_r == IDX_PIPE2)
                    p2_nxt = byte_wdata;
                else if (sel_r == IDX_PIPE3)
                    p3_nxt = byte_wdata;
                else if (sel_r == IDX_PIPE4)
                    p4_nxt = byte_wdata;
                else if (sel_r == IDX_PIPE5)
                    p5_nxt = byte_wdata;
            end
        end
        // Upper bytes follow pipe 1
        f2_nxt = {p1_nxt[39:8], p2_nxt};
        f3_nxt = {p1_nxt[39:8], p3_nxt};
        f4_nxt = {p1_nxt[39:8], p4_nxt};
        f5_nxt = {p1_nxt[39:8], p5_nxt};
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_pipe0_address <= PIPE0_RESET;
            rx_pipe1_address <= PIPE1_RESET;
            p2_r <= PIPE2_RESET;
            p3_r <= PIPE3_RESET;
            p4_r <= PIPE4_RESET;
            p5_r <= PIPE5_RESET;
            pipe2_full_r <= {PIPE1_RESET[39:8], PIPE2_RESET};
            pipe3_full_r <= {PIPE1_RESET[39:8], PIPE3_RESET};
            pipe4_full_r <= {PIPE1_RESET[39:8], PIPE4_RESET};
            pipe5_full_r <= {PIPE1_RESET[39:8], PIPE5_RESET};
        end
        else
        begin
            rx_pipe0_address <= p0_nxt;
            rx_pipe1_address <= p1_nxt;
            p2_r <= p2_nxt;
            p3_r <= p3_nxt;
            p4_r <= p4_nxt;
            p5_r <= p5_nxt;
            pipe2_full_r <= f2_nxt;
            pipe3_full_r <= f3_nxt;
            pipe4_full_r <= f4_nxt;
            pipe5_full_r <= f5_nxt;
        end
    end

    // Read data for the current byte
    always_comb
    begin
        rd_nxt = BYTE_ZERO;
        if (sel_nxt == IDX_PIPE0)
            rd_nxt = byte_of(p0_nxt, bidx_nxt);
        else if (sel_nxt == IDX_PIPE1)
            rd_nxt = byte_of(p1_nxt, bidx_nxt);
        else if (bidx_nxt == 3'h0)
        begin
            if (sel_nxt == IDX_OBSERVE)
                rd_nxt = {lost_packet_count, retransmit_count};
            else if (sel_nxt == IDX_CARRIER)
                rd_nxt = {7'h00, carrier_detect_flag};
            else if (sel_nxt == IDX_PIPE2)
                rd_nxt = p2_nxt;
            else if (sel_nxt == IDX_PIPE3)
                rd_nxt = p3_nxt;
            else if (sel_nxt == IDX_PIPE4)
                rd_nxt = p4_nxt;
            else if (sel_nxt == IDX_PIPE5)
                rd_nxt = p5_nxt;
        end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
            rd_data_r <= BYTE_ZERO;
        else
            rd_data_r <= rd_nxt;
    end

    // Carrier input comes from the radio, outside this clock
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            cd_meta_r <= 1'b0;
            cd_sync_r <= 1'b0;
            carrier_detect_flag <= 1'b0;
        end
        else
        begin
            cd_meta_r <= carrier_in;
            cd_sync_r <= cd_meta_r;
            carrier_detect_flag <= cd_sync_r;
        end
    end
endmodule

// *** verification/txobs_regs_sva.sv ***
// Checker for the observation and receive address register slice.
// Assumes binding into the top module; sees only its ports.
`timescale 1ns/100ps
module txobs_regs_chk
    import txobs_addr_pkg::*;
(
    // Clock, reset and inputs
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic acc_start,
    input wire logic [4:0] acc_index,
    input wire logic acc_write,
    input wire logic chan_write,
    input wire logic [1:0] address_width_setting,
    input wire logic tx_new_packet,
    input wire logic tx_lost,
    // Outputs
    input wire logic [7:0] rd_data_r,
    input wire logic [39:0] rx_pipe0_address,
    input wire logic [39:0] rx_pipe1_address,
    input wire logic [39:0] pipe2_full_r,
    input wire logic [39:0] pipe5_full_r,
    input wire logic [3:0] lost_packet_count,
    input wire logic [3:0] retransmit_count
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    AST_LOST_HOLD: assert property (
        lost_packet_count == CNT_MAX && !chan_write
        |=> lost_packet_count == CNT_MAX) else $error("lost count left max");
    AST_LOST_CLR: assert property (
        chan_write && !tx_lost |=> lost_packet_count == CNT_RESET)
        else $error("lost count not cleared");
    AST_RETR_CLR: assert property (
        tx_new_packet |=> retransmit_count == CNT_RESET)
        else $error("retransmit count not cleared");
    AST_CARRIER_RSVD: assert property (
        acc_start && acc_index == IDX_CARRIER && !acc_write
        |-> ##1 rd_data_r[7:1] == 7'h00) else $error("carrier upper bits set");
    AST_UPPER_SHARED: assert property (
        $stable(rx_pipe1_address) |-> pipe2_full_r[39:8] ==
        rx_pipe1_address[39:8] && pipe5_full_r[39:8] ==
        rx_pipe1_address[39:8]) else $error("shared upper bytes differ");
    AST_RESET_VAL: assert property (
        $rose(resetn) |-> rx_pipe0_address == PIPE0_RESET &&
        rx_pipe1_address == PIPE1_RESET && pipe5_full_r[7:0] == PIPE5_RESET)
        else $error("address reset value wrong");
    AST_WIDTH_ILLEGAL: assert property (
        address_width_setting == AW_ILLEGAL |=> $stable(rx_pipe0_address)
        && $stable(rx_pipe1_address)) else $error("write with width 00");
    AST_LOST_INC: assert property (
        tx_lost && !chan_write && lost_packet_count != CNT_MAX
        |=> lost_packet_count == $past(lost_packet_count) + 4'h1)
        else $error("lost count did not step");
endmodule
bind tx_observe_rx_address_regs txobs_regs_chk chk
(
    .clk_sys(clk_sys),
    .resetn(resetn),
    .acc_start(acc_start),
    .acc_index(acc_index),
    .acc_write(acc_write),
    .chan_write(chan_write),
    .address_width_setting(address_width_setting),
    .tx_new_packet(tx_new_packet),
    .tx_lost(tx_lost),
    .rd_data_r(rd_data_r),
    .rx_pipe0_address(rx_pipe0_address),
    .rx_pipe1_address(rx_pipe1_address),
    .pipe2_full_r(pipe2_full_r),
    .pipe5_full_r(pipe5_full_r),
    .lost_packet_count(lost_packet_count),
    .retransmit_count(retransmit_count)
);

// *** verification/host_access_model.sv ***
// Host model driving the byte-wide register access port.
// Assumes its tasks are called at a falling edge of clk_sys.
`timescale 1ns/100ps
module host_access_model
(
    // Clock
    input wire logic clk_sys,
    // Access port
    output logic acc_start,
    output logic [4:0] acc_index,
    output logic acc_write,
    output logic byte_valid,
    output logic [7:0] byte_wdata,
    input wire logic [7:0] rd_data_r
);
    initial
    begin
        {acc_start, acc_write, byte_valid} = 3'h0;
        acc_index = 5'h00;
        byte_wdata = 8'h00;
    end
    task automatic acc(input logic [4:0] idx, input logic wr);
        acc_start = 1'b1;
        acc_index = idx;
        acc_write = wr;
        @(negedge clk_sys);
        acc_start = 1'b0;
        acc_index = ~idx;
        acc_write = ~wr;
    endtask
    // Bytes go out in call order; caller sends the low byte first
    task automatic put(input logic [7:0] b, input logic last);
        byte_valid = 1'b1;
        byte_wdata = b;
        @(negedge clk_sys);
        if (last)
        begin
            byte_valid = 1'b0;
            byte_wdata = ~b;
        end
    endtask
    task automatic get(output logic [7:0] b, input logic last);
        b = rd_data_r;
        byte_valid = 1'b1;
        @(negedge clk_sys);
        if (last)
            byte_valid = 1'b0;
    endtask
endmodule

// *** verification/test_tx_observe_rx_address_regs.sv ***
// Self-checking bench for the observation and receive address registers.
// Assumes the host model owns the access port.
`timescale 1ns/100ps
module test_tx_observe_rx_address_regs
    import txobs_addr_pkg::*;
;
    logic clk_sys, resetn, acc_start, acc_write, byte_valid, chan_write;
    logic tx_new_packet, tx_retransmit, tx_lost, carrier_in;
    logic carrier_detect_flag;
    logic [4:0] acc_index;
    logic [7:0] byte_wdata, rd_data_r;
    logic [1:0] address_width_setting;
    logic [39:0] rx_pipe0_address, rx_pipe1_address, pipe2_full_r;
    logic [39:0] pipe3_full_r, pipe4_full_r, pipe5_full_r;
    logic [3:0] lost_packet_count, retransmit_count;
    int n_mismatch, comparisons;

    tx_observe_rx_address_regs dut
    (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .acc_start(acc_start),
        .acc_index(acc_index),
        .acc_write(acc_write),
        .byte_valid(byte_valid),
        .byte_wdata(byte_wdata),
        .rd_data_r(rd_data_r),
        .chan_write(chan_write),
        .address_width_setting(address_width_setting),
        .tx_new_packet(tx_new_packet),
        .tx_retransmit(tx_retransmit),
        .tx_lost(tx_lost),
        .carrier_in(carrier_in),
        .rx_pipe0_address(rx_pipe0_address),
        .rx_pipe1_address(rx_pipe1_address),
        .pipe2_full_r(pipe2_full_r),
        .pipe3_full_r(pipe3_full_r),
        .pipe4_full_r(pipe4_full_r),
        .pipe5_full_r(pipe5_full_r),
        .lost_packet_count(lost_packet_count),
        .retransmit_count(retransmit_count),
        .carrier_detect_flag(carrier_detect_flag)
    );
    host_access_model h
    (
        .clk_sys(clk_sys),
        .acc_start(acc_start),
        .acc_index(acc_index),
        .acc_write(acc_write),
        .byte_valid(byte_valid),
        .byte_wdata(byte_wdata),
        .rd_data_r(rd_data_r)
    );

    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // Pulse {chan, new packet, retransmit, lost} n times
    task automatic ev(input logic [3:0] m, input int n);
        repeat (n)
        begin
            {chan_write, tx_new_packet, tx_retransmit, tx_lost} = m;
            @(negedge clk_sys);
            {chan_write, tx_new_packet, tx_retransmit, tx_lost} = 4'h0;
            @(negedge clk_sys);
        end
    endtask
    task automatic wr(input logic [4:0] idx, input logic [39:0] v, int n);
        h.acc(idx, 1'b1);
        for (int i = 0; i < n; i++)
            h.put(v[8*i+:8], i == n - 1);
    endtask
    task automatic rd(input logic [4:0] idx, input logic [39:0] e, int n);
        logic [7:0] b;
        h.acc(idx, 1'b0);
        for (int i = 0; i < n; i++)
        begin
            h.get(b, i == n - 1);
            chk(40'(b), 40'(e[8*i+:8]));
        end
    endtask
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial
    begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        complete_run;
    end
    initial
    begin
        resetn = 1'b0;
        ev(4'h0, 0);
        {chan_write, tx_new_packet, tx_retransmit, tx_lost} = 4'h0;
        carrier_in = 1'b0;
        address_width_setting = AW_5;
        repeat (5) @(negedge clk_sys);
        resetn = 1'b1;
        chk(rx_pipe1_address, PIPE1_RESET);
        rd(IDX_PIPE0, PIPE0_RESET, 5);
        rd(IDX_PIPE4, {32'h0, PIPE4_RESET}, 2);
        wr(IDX_PIPE1, 40'h55_4433_2211, 5);
        chk(rx_pipe1_address, 40'h55_4433_2211);
        for (int i = 0; i < 4; i++)
            wr(IDX_PIPE2 + 5'(i), 40'(8'h10 + i), 1);
        chk(pipe2_full_r, 40'h55_4433_2210);
        chk(pipe3_full_r, 40'h55_4433_2211);
        chk(pipe4_full_r, 40'h55_4433_2212);
        chk(pipe5_full_r, 40'h55_4433_2213);
        // Bytes past a 3-byte width are dropped
        address_width_setting = AW_3;
        wr(IDX_PIPE0, 40'ha5_a4a3_a2a1, 5);
        chk(rx_pipe0_address, 40'he7_e7a3_a2a1);
        address_width_setting = AW_4;
        // Pipe 0 takes a 4-byte address at width 4; byte 4 keeps E7
        wr(IDX_PIPE0, 40'hb5_b4b3_b2b1, 4);
        chk(rx_pipe0_address, 40'he7_b4b3_b2b1);
        address_width_setting = AW_ILLEGAL;
        wr(IDX_PIPE1, 40'h0, 5);
        chk(rx_pipe1_address, 40'h55_4433_2211);
        address_width_setting = AW_5;
        ev(4'h1, 17);
        chk(40'(lost_packet_count), 40'(CNT_MAX));
        rd(IDX_OBSERVE, 40'hf0, 1);
        ev(4'h8, 1);
        chk(40'(lost_packet_count), 40'(CNT_RESET));
        // Loss in the clearing cycle still counts
        ev(4'h9, 1);
        chk(40'(lost_packet_count), 40'h1);
        ev(4'h2, 3);
        chk(40'(retransmit_count), 40'h3);
        ev(4'h4, 1);
        chk(40'(retransmit_count), 40'(CNT_RESET));
        chk(40'(carrier_detect_flag), 40'h0);
        carrier_in = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(40'(carrier_detect_flag), 40'h1);
        wr(IDX_CARRIER, 40'hfe, 1);
        rd(IDX_CARRIER, 40'h01, 2);
        complete_run;
    end
endmodule
